/* File: core/cfe_pkg.sv */
// constants and types shared by the condition flag evaluator
package cfe_pkg;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned SIGN_BIT = 31;
    localparam int unsigned PC_STEP  = 4;
    localparam int unsigned ALIGN_BIT = 1;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_V = 0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // condition codes, standard four-bit encoding
    typedef enum logic [3:0] {
        cond_same_value         = 4'h0,
        cond_differ             = 4'h1,
        cond_carry_set_alias    = 4'h2,
        cond_carry_clear        = 4'h3,
        cond_negative           = 4'h4,
        cond_nonnegative        = 4'h5,
        cond_overflow_set       = 4'h6,
        cond_overflow_clear     = 4'h7,
        cond_unsigned_above     = 4'h8,
        cond_unsigned_not_above = 4'h9,
        cond_signed_at_least    = 4'hA,
        cond_signed_below       = 4'hB,
        cond_signed_above       = 4'hC,
        cond_signed_at_most     = 4'hD,
        cond_no_test            = 4'hE,
        cond_no_test_alt        = 4'hF
    } cfe_cond_type;

    // how the carry and overflow flags are formed
    typedef enum logic [1:0] {
        cfe_op_add   = 2'h0,
        cfe_op_sub   = 2'h1,
        cfe_op_logic = 2'h2
    } cfe_op_type;

    // branch kinds; all use the plain pc base except cfe_pc_label, which clears bit 1
    typedef enum logic [1:0] {
        cfe_pc_branch            = 2'h0,
        cfe_pc_label             = 2'h1,
        cfe_pc_branch_if_zero    = 2'h2,
        cfe_pc_branch_if_nonzero = 2'h3
    } cfe_pc_type;
endpackage

/* File: core/cfe_cond_check.sv */
// combinational condition code test against the four flags
module cfe_cond_check (
    // flags and code
    input  wire logic              flag_n,
    input  wire logic              flag_z,
    input  wire logic              flag_c,
    input  wire logic              flag_v,
    input  wire cfe_pkg::cfe_cond_type cond,
    // result
    output logic                   pass
);
    import cfe_pkg::*;

    // pure decode, no state, so the answer is ready in the issue cycle
    always_comb begin
        pass = 1'b0;
        unique case (cond)
            cond_same_value:         pass = flag_z;
            cond_differ:             pass = !flag_z;
            cond_carry_set_alias:    pass = flag_c;
            cond_carry_clear:        pass = !flag_c;
            cond_negative:           pass = flag_n;
            cond_nonnegative:        pass = !flag_n;
            cond_overflow_set:       pass = flag_v;
            cond_overflow_clear:     pass = !flag_v;
            cond_unsigned_above:     pass = flag_c && !flag_z;
            cond_unsigned_not_above: pass = !flag_c || flag_z;
            cond_signed_at_least:    pass = (flag_n == flag_v);
            cond_signed_below:       pass = (flag_n != flag_v);
            cond_signed_above:       pass = !flag_z && (flag_n == flag_v);
            cond_signed_at_most:     pass = flag_z || (flag_n != flag_v);
            cond_no_test:            pass = 1'b1;
            cond_no_test_alt:        pass = 1'b1;
        endcase
    end
endmodule

/* File: core/cfe_flag_unit.sv */
// flag generation, flag holding, condition test and pc base forming
// What this block does
// - negative flag copies result bit 31 on a flag update.
// - zero flag is set when the result is all zero.
// - carry flag reflects the carry of the operation.
// - overflow flag reflects signed overflow of the operation.
// - addition carry set when the full sum reaches two to the 32.
// - subtraction carry set when no borrow occurs.
// - move and logical carry comes from the barrel shifter.
// - overflow when result sign differs from infinite precision sign.
// - compares set flags like sub or add but write no result.
// - flags not selected for update keep their old value.
// - flags change only when the set-flags bit is present.
// - failed condition suppresses write, flags and exceptions.
// - equal, not equal, carry set and clear test Z and C.
// - unsigned above needs C and not Z; not above is the inverse.
// - signed at least when N equals V; sign tests use N.
// - signed above and at most use Z with N and V; V tests.
// - the no-test condition always passes.
// - branches use instruction address plus four as pc base.
// - other label users use address plus four with bit 1 cleared.
// - zero-compare branches test a register without an if-then prefix.
// - conditions see flags from the latest flag-updating instruction.
//
// Design decisions made here: the placing of the registers.
module cfe_flag_unit (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // instruction issue from decode
    input  wire logic                        issue,
    input  wire cfe_pkg::cfe_cond_type       cond,
    input  wire logic                        set_flags,
    input  wire logic [3:0]                  flag_mask,
    input  wire logic                        is_compare,
    input  wire logic                        raise_exc,
    // operands from execute
    input  wire cfe_pkg::cfe_op_type         op_kind,
    input  wire logic [cfe_pkg::DATA_W-1:0]  op_a,
    input  wire logic [cfe_pkg::DATA_W-1:0]  op_b,
    input  wire logic [cfe_pkg::DATA_W-1:0]  logic_result,
    input  wire logic                        shift_carry,
    // pc relative and zero-compare branches
    input  wire logic [cfe_pkg::DATA_W-1:0]  instr_addr,
    input  wire cfe_pkg::cfe_pc_type         pc_kind,
    input  wire logic [cfe_pkg::DATA_W-1:0]  test_reg,
    // results
    output logic                             cond_pass,
    output logic                             reg_write,
    output logic                             exc_out,
    output logic                             zb_taken,
    output logic [cfe_pkg::DATA_W-1:0]       result,
    output logic [cfe_pkg::DATA_W-1:0]       pc_base,
    output logic [3:0]                       app_status_word
);
    import cfe_pkg::*;

    logic [3:0]        flags_r;
    logic [3:0]        flags_nxt;
    logic [DATA_W:0]   wide_sum;
    logic [DATA_W-1:0] calc;
    logic              carry_calc;
    logic              ovf_calc;
    logic              neg_calc;
    logic              zero_calc;
    logic              execute;
    logic [DATA_W-1:0] pc_plus;
    logic [DATA_W-1:0] result_nxt;
    logic [DATA_W:0]   sx_sum;
    logic [DATA_W:0]   sx_dif;

    cfe_cond_check u_cond (
        .flag_n (flags_r[FLAG_N]),
        .flag_z (flags_r[FLAG_Z]),
        .flag_c (flags_r[FLAG_C]),
        .flag_v (flags_r[FLAG_V]),
        .cond   (cond),
        .pass   (cond_pass)
    );

    assign execute = issue && cond_pass;

    // arithmetic at 33 bits so the carry out is visible
    always_comb begin
        wide_sum   = '0;
        calc       = logic_result;
        carry_calc = shift_carry;
        ovf_calc   = flags_r[FLAG_V];
        unique case (op_kind)
            cfe_op_add: begin
                wide_sum   = {1'b0, op_a} + {1'b0, op_b};
                calc       = wide_sum[DATA_W-1:0];
                // carry at or above two to 32
                carry_calc = wide_sum[DATA_W];
                ovf_calc   = (op_a[SIGN_BIT] == op_b[SIGN_BIT])
                             && (calc[SIGN_BIT] != op_a[SIGN_BIT]);
            end
            cfe_op_sub: begin
                wide_sum   = {1'b0, op_a} + {1'b0, ~op_b} + {{DATA_W{1'b0}}, 1'b1};
                calc       = wide_sum[DATA_W-1:0];
                carry_calc = wide_sum[DATA_W];
                ovf_calc   = (op_a[SIGN_BIT] != op_b[SIGN_BIT])
                             && (calc[SIGN_BIT] != op_a[SIGN_BIT]);
            end
            cfe_op_logic: begin
                calc       = logic_result;
                carry_calc = shift_carry;
                ovf_calc   = flags_r[FLAG_V];
            end
            default: begin
                calc       = logic_result;
                carry_calc = shift_carry;
                ovf_calc   = flags_r[FLAG_V];
            end
        endcase
    end

    assign neg_calc  = calc[SIGN_BIT];
    assign zero_calc = (calc == '0);

    // per-flag select; masked flags fall through to the old value
    always_comb begin
        flags_nxt = flags_r;
        // set-flags bit required; failed test leaves flags
        if (execute && set_flags) begin
            if (flag_mask[FLAG_N]) flags_nxt[FLAG_N] = neg_calc;
            if (flag_mask[FLAG_Z]) flags_nxt[FLAG_Z] = zero_calc;
            if (flag_mask[FLAG_C]) flags_nxt[FLAG_C] = carry_calc;
            if (flag_mask[FLAG_V]) flags_nxt[FLAG_V] = ovf_calc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign app_status_word = flags_r;

    // compares never write; failed test never writes
    assign reg_write = execute && !is_compare;
    assign exc_out   = execute && raise_exc;

    // result register holds last written value
    assign result_nxt = reg_write ? calc : result;
    always_ff @(posedge clk) begin
        if (rst) begin
            result <= '0;
        end else begin
            result <= result_nxt;
        end
    end

    assign pc_plus = instr_addr + DATA_W'(PC_STEP);

    // pc base registered with the instruction
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_base <= '0;
        end else if (issue) begin
            if (pc_kind == cfe_pc_label) begin
                // word align by clearing bit 1
                pc_base <= pc_plus & ~(DATA_W'(1) << ALIGN_BIT);
            end else begin
                pc_base <= pc_plus;
            end
        end
    end

    // zero-compare branch needs no prefix, ignores cond
    assign zb_taken = issue && (((pc_kind == cfe_pc_branch_if_zero) && (test_reg == '0))
                      || ((pc_kind == cfe_pc_branch_if_nonzero) && (test_reg != '0)));

    // sign-extended sums, read by the overflow checks only
    assign sx_sum = {op_a[SIGN_BIT], op_a} + {op_b[SIGN_BIT], op_b};
    assign sx_dif = {op_a[SIGN_BIT], op_a} - {op_b[SIGN_BIT], op_b};

    // assertions and covers
    property p_neg_flag;
        @(posedge clk) disable iff (rst)
        (execute && set_flags && flag_mask[FLAG_N]) |=>
            (flags_r[FLAG_N] == $past(calc[SIGN_BIT]));
    endproperty
    a_neg_flag: assert property (p_neg_flag) else $error("N flag wrong");

    property p_zero_flag;
        @(posedge clk) disable iff (rst)
        (execute && set_flags && flag_mask[FLAG_Z]) |=>
            (flags_r[FLAG_Z] == ($past(calc) == '0));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("Z flag wrong");

    property p_add_carry;
        @(posedge clk) disable iff (rst)
        (execute && set_flags && flag_mask[FLAG_C] && op_kind == cfe_op_add) |=>
            (flags_r[FLAG_C] == ({1'b0, $past(op_a)} + {1'b0, $past(op_b)} >= 33'h100000000));
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_sub_carry;
        @(posedge clk) disable iff (rst)
        (execute && set_flags && flag_mask[FLAG_C] && op_kind == cfe_op_sub) |=>
            (flags_r[FLAG_C] == ($past(op_a) >= $past(op_b)));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("sub carry wrong");

    property p_logic_carry;
        @(posedge clk) disable iff (rst)
        (execute && set_flags && flag_mask[FLAG_C] && op_kind == cfe_op_logic) |=>
            (flags_r[FLAG_C] == $past(shift_carry));
    endproperty
    a_logic_carry: assert property (p_logic_carry) else $error("shift carry wrong");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !(execute && set_flags) |=> $stable(flags_r);
    endproperty
    a_hold: assert property (p_hold) else $error("flags moved without update");

    property p_compare_nowrite;
        @(posedge clk) disable iff (rst)
        is_compare |-> !reg_write;
    endproperty
    a_compare_nowrite: assert property (p_compare_nowrite) else $error("compare wrote");

    property p_fail_suppress;
        @(posedge clk) disable iff (rst)
        (issue && !cond_pass) |-> (!reg_write && !exc_out) ##1 $stable(flags_r);
    endproperty
    a_fail_suppress: assert property (p_fail_suppress) else $error("failed cond acted");

    property p_pc_label;
        @(posedge clk) disable iff (rst)
        (issue && pc_kind == cfe_pc_label) |=>
            (pc_base == (($past(instr_addr) + 32'h4) & 32'hFFFFFFFD));
    endproperty
    a_pc_label: assert property (p_pc_label) else $error("aligned pc base wrong");

    property p_pc_branch;
        @(posedge clk) disable iff (rst)
        (issue && pc_kind != cfe_pc_label) |=> (pc_base == $past(instr_addr) + 32'h4);
    endproperty
    a_pc_branch: assert property (p_pc_branch) else $error("branch pc base wrong");

    property p_always;
        @(posedge clk) disable iff (rst)
        (cond == cond_no_test) |-> cond_pass;
    endproperty
    a_always: assert property (p_always) else $error("always failed");

    property p_add_ovf;
        @(posedge clk) disable iff (rst)
        (execute && set_flags && flag_mask[FLAG_V] && op_kind == cfe_op_add) |=>
            (flags_r[FLAG_V] == $past(sx_sum[DATA_W] != sx_sum[SIGN_BIT]));
    endproperty
    a_add_ovf: assert property (p_add_ovf) else $error("add overflow wrong");

    property p_sub_ovf;
        @(posedge clk) disable iff (rst)
        (execute && set_flags && flag_mask[FLAG_V] && op_kind == cfe_op_sub) |=>
            (flags_r[FLAG_V] == $past(sx_dif[DATA_W] != sx_dif[SIGN_BIT]));
    endproperty
    a_sub_ovf: assert property (p_sub_ovf) else $error("sub overflow wrong");

    property p_mask_keep;
        @(posedge clk) disable iff (rst)
        execute |=> (((flags_r ^ $past(flags_r)) & ~$past(flag_mask)) == 4'h0);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("unmasked flag moved");

    property p_logic_keep_v;
        @(posedge clk) disable iff (rst)
        (execute && op_kind == cfe_op_logic) |=> $stable(flags_r[FLAG_V]);
    endproperty
    a_logic_keep_v: assert property (p_logic_keep_v) else $error("logic moved V");

    property p_pass_acts;
        @(posedge clk) disable iff (rst)
        (issue && cond_pass) |-> ((reg_write == !is_compare) && (exc_out == raise_exc));
    endproperty
    a_pass_acts: assert property (p_pass_acts) else $error("passed instr idle");

    property p_result_hold;
        @(posedge clk) disable iff (rst)
        !reg_write |=> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");

    property p_pc_hold;
        @(posedge clk) disable iff (rst)
        !issue |=> $stable(pc_base);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc base moved idle");

    property p_zero_branch;
        @(posedge clk) disable iff (rst)
        (issue && pc_kind == cfe_pc_branch_if_zero) |-> (zb_taken == (test_reg == '0));
    endproperty
    a_zero_branch: assert property (p_zero_branch) else $error("zero branch wrong");

    property p_nonzero_branch;
        @(posedge clk) disable iff (rst)
        (issue && pc_kind == cfe_pc_branch_if_nonzero) |-> (zb_taken == (test_reg != '0));
    endproperty
    a_nonzero_branch: assert property (p_nonzero_branch) else $error("nonzero branch wrong");

    property p_no_branch;
        @(posedge clk) disable iff (rst)
        (!issue || pc_kind == cfe_pc_branch || pc_kind == cfe_pc_label) |-> !zb_taken;
    endproperty
    a_no_branch: assert property (p_no_branch) else $error("stray zero branch");

    property p_signed_above;
        @(posedge clk) disable iff (rst)
        (cond == cond_signed_above) |-> (cond_pass == (!app_status_word[FLAG_Z]
            && (app_status_word[FLAG_N] == app_status_word[FLAG_V])));
    endproperty
    a_signed_above: assert property (p_signed_above) else $error("signed above wrong");

    c_cmp_then_cond: cover property (@(posedge clk) disable iff (rst)
        (execute && is_compare && set_flags) ##[1:4] (issue && !cond_pass));
    c_overflow: cover property (@(posedge clk) disable iff (rst)
        execute && set_flags && ovf_calc && op_kind == cfe_op_add);
    c_zero_branch: cover property (@(posedge clk) disable iff (rst) zb_taken);
    c_sub_overflow: cover property (@(posedge clk) disable iff (rst)
        execute && set_flags && ovf_calc && op_kind == cfe_op_sub);
endmodule

/* File: verif/cfe_exec_model.sv */
// execute and decode stand-in that feeds operands and flag controls
module cfe_exec_model (
    // requested operation
    input  wire logic [1:0]          kind_req,
    input  wire logic [31:0]         a_req,
    input  wire logic [31:0]         b_req,
    input  wire logic [3:0]          mask_req,
    input  wire logic                sf_req,
    input  wire logic                cmp_req,
    // toward the flag unit
    output cfe_pkg::cfe_op_type      op_kind,
    output logic [31:0]              op_a,
    output logic [31:0]              op_b,
    output logic [31:0]              logic_result,
    output logic                     shift_carry,
    output logic [3:0]               flag_mask,
    output logic                     set_flags,
    output logic                     is_compare
);
    timeunit 1ns;
    timeprecision 1ps;
    import cfe_pkg::*;
    logic [4:0] sh;

    // shift right by 1..31 only, so the shifter carry is always defined
    always_comb begin
        sh           = a_req[4:0] | 5'h01;
        op_kind      = cfe_op_type'(kind_req);
        op_a         = a_req;
        op_b         = b_req;
        logic_result = b_req >> sh;
        shift_carry  = b_req[sh - 5'h01];
        // compares always set flags
        set_flags    = sf_req | cmp_req;
        is_compare   = cmp_req;
        // logical ops leave overflow alone, so decode drops that mask bit
        flag_mask    = kind_req[1] ? (mask_req & 4'hE) : mask_req;
    end
endmodule

/* File: verif/cfe_flag_unit_tb.sv */
// self-checking bench for the condition flag evaluator
module cfe_flag_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfe_pkg::*;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               issue = 1'b0;
    cfe_cond_type       cond = cond_no_test;
    logic               raise_exc = 1'b0;
    logic [31:0]        instr_addr = 32'h0;
    cfe_pc_type         pc_kind = cfe_pc_branch;
    logic [31:0]        test_reg = 32'h0;
    logic [1:0]         kind_req = 2'h0;
    logic [31:0]        a_req = 32'h0;
    logic [31:0]        b_req = 32'h0;
    logic [3:0]         mask_req = 4'h0;
    logic               sf_req = 1'b0;
    logic               cmp_req = 1'b0;
    cfe_op_type         op_kind;
    logic [31:0]        op_a, op_b, logic_result, result, pc_base;
    logic               shift_carry, set_flags, is_compare;
    logic [3:0]         flag_mask, app_status_word;
    logic               cond_pass, reg_write, exc_out, zb_taken;
    logic [3:0]         m_flags;
    logic [31:0]        m_result, m_pc, res, seed = 32'd51;
    logic [32:0]        sum;
    logic               ok, cy, v, ep, zb;
    int                 n_mismatch = 0, n_tests = 0, cyc = 0;
    logic [65:0]        dir [8] = '{{2'h1, 32'h5, 32'h5}, {2'h0, 32'hFFFFFFFF, 32'h1},
        {2'h0, 32'h7FFFFFFF, 32'h1}, {2'h0, 32'h80000000, 32'h80000000},
        {2'h1, 32'h0, 32'h1}, {2'h1, 32'h80000000, 32'h1},
        {2'h1, 32'h7FFFFFFF, 32'hFFFFFFFF}, {2'h2, 32'h1, 32'h3}};

    always #5 clk = ~clk;

    cfe_exec_model partner (.kind_req(kind_req), .a_req(a_req), .b_req(b_req),
        .mask_req(mask_req), .sf_req(sf_req), .cmp_req(cmp_req), .op_kind(op_kind),
        .op_a(op_a), .op_b(op_b), .logic_result(logic_result), .shift_carry(shift_carry),
        .flag_mask(flag_mask), .set_flags(set_flags), .is_compare(is_compare));

    cfe_flag_unit dut (.clk(clk), .rst(rst), .issue(issue), .cond(cond),
        .set_flags(set_flags), .flag_mask(flag_mask), .is_compare(is_compare),
        .raise_exc(raise_exc), .op_kind(op_kind), .op_a(op_a), .op_b(op_b),
        .logic_result(logic_result), .shift_carry(shift_carry), .instr_addr(instr_addr),
        .pc_kind(pc_kind), .test_reg(test_reg), .cond_pass(cond_pass),
        .reg_write(reg_write), .exc_out(exc_out), .zb_taken(zb_taken), .result(result),
        .pc_base(pc_base), .app_status_word(app_status_word));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic f_pass(input logic [3:0] f, input logic [3:0] c);
        case (c[3:1])
            3'h0: f_pass = f[2];
            3'h1: f_pass = f[1];
            3'h2: f_pass = f[3];
            3'h3: f_pass = f[0];
            3'h4: f_pass = f[1] && !f[2];
            3'h5: f_pass = f[3] == f[0];
            3'h6: f_pass = !f[2] && (f[3] == f[0]);
            default: f_pass = 1'b1;
        endcase
        if (c[3:1] != 3'h7 && c[0]) f_pass = !f_pass;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one instruction per cycle, side fields random
    task automatic instr(input logic [1:0] k, input logic [31:0] a, b,
                         input logic [3:0] c, m, input logic sf, cp);
        logic [31:0] x;
        x = xs();
        @(posedge clk);
        issue      <= 1'b1;
        kind_req   <= k;
        a_req      <= a;
        b_req      <= b;
        cond       <= cfe_cond_type'(c);
        mask_req   <= m;
        sf_req     <= sf;
        cmp_req    <= cp;
        raise_exc  <= x[0];
        pc_kind    <= cfe_pc_type'(x[2:1]);
        instr_addr <= x & 32'hFFFFFFFE;
        test_reg   <= x[3] ? 32'h0 : x;
    endtask

    // reference model: state advances on the same edge as the design
    always @(posedge clk) begin
        if (rst) begin
            m_flags  = 4'h0;
            m_result = 32'h0;
            m_pc     = 32'h0;
        end else if (issue) begin
            ok   = f_pass(m_flags, cond);
            m_pc = instr_addr + 32'h4;
            if (pc_kind == cfe_pc_label) m_pc[1] = 1'b0;
            sum = {1'b0, op_a} + {1'b0, op_b};
            case (op_kind)
                cfe_op_add: begin
                    res = sum[31:0];
                    cy  = sum[32];
                    v   = (op_a[31] == op_b[31]) && (res[31] != op_a[31]);
                end
                cfe_op_sub: begin
                    res = op_a - op_b;
                    cy  = op_a >= op_b;
                    v   = (op_a[31] != op_b[31]) && (res[31] != op_a[31]);
                end
                default: begin
                    res = logic_result;
                    cy  = shift_carry;
                    v   = m_flags[0];
                end
            endcase
            if (ok && !is_compare) m_result = res;
            if (ok && set_flags)
                m_flags = (m_flags & ~flag_mask) | ({res[31], res == 32'h0, cy, v} & flag_mask);
        end
    end

    // compare mid-cycle, when every output has settled
    always @(negedge clk) begin
        if (!rst) begin
            ep = f_pass(m_flags, cond);
            chk(cond_pass, ep);
            chk(reg_write, issue && ep && !is_compare);
            chk(exc_out, issue && ep && raise_exc);
            zb = issue && ((pc_kind == cfe_pc_branch_if_zero && test_reg == 32'h0) ||
                (pc_kind == cfe_pc_branch_if_nonzero && test_reg != 32'h0));
            chk(zb_taken, zb);
            chk(app_status_word, m_flags);
            chk(result, m_result);
            chk(pc_base, m_pc);
        end
    end

    task automatic results();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        logic [31:0] r, q;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // boundary operands, then every code probed without touching flags
        foreach (dir[i]) begin
            instr(dir[i][65:64], dir[i][63:32], dir[i][31:0], 4'hE, 4'hF, 1'b1, 1'b0);
            for (int c = 0; c < 16; c++)
                instr(2'h1, xs(), xs(), c[3:0], 4'hF, 1'b0, 1'b0);
        end
        // random mix of masks, compares and conditions
        repeat (3000) begin
            r = xs();
            q = xs();
            // equal operands now and then, so subtracts reach a zero result
            instr(r[1:0], q, r[2] ? q : xs(), r[7:4], r[11:8], r[12], r[13] & r[14]);
        end
        @(posedge clk);
        issue <= 1'b0;
        repeat (2) @(posedge clk);
        results();
    end
endmodule
